/* File: rtl/star_cfg_pkg.sv */
// constants, field positions and carrier types of the star coupler configuration block
// assumes a single 125 MHz core clock; spi and line inputs arrive from pins
package star_cfg_pkg;

    // =====================================================================
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 13;
    localparam int RO_BIT = 12;
    localparam int DATA_W = 12;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] ADDR_DONE = 5'h04;

    // =====================================================================
    // register addresses
    localparam logic [2:0] ADDR_CONFIG = 3'h7;
    localparam logic [2:0] ADDR_GEN_STATUS = 3'h2;
    localparam logic [2:0] ADDR_BR1_STATUS = 3'h3;
    localparam logic [2:0] ADDR_BR2_STATUS = 3'h4;

    // =====================================================================
    // configuration fields
    localparam int BIT_AUTO_CONFINE = 11;
    localparam int BIT_BUS_FAIL_TIMER = 10;
    localparam int BIT_WAKE_BR1 = 9;
    localparam int BIT_WAKE_BR2 = 8;
    localparam int BIT_CTRL_PORT = 5;
    localparam int BIT_INNER_STAR = 4;
    localparam int BIT_STUCK_DETECT = 2;
    localparam int BIT_LATCHING = 1;
    localparam int BIT_PARITY = 0;
    localparam logic [11:0] CONFIG_RESET = 12'h7D4;
    localparam logic [11:0] CONFIG_WMASK = 12'hFF6;
    // only chip select idles high; every other pin idles low
    localparam logic [11:0] SYNC_RESET = 12'h002;

    // =====================================================================
    // timing
    localparam int CLK_MHZ = 125;
    localparam int BUS_FAIL_TIME_NS = 1000;
    localparam int BFT_CNT_W = 16;

    // =====================================================================
    // synchronised pin vector positions
    localparam int PIN_W = 12;
    localparam int PIN_SCLK = 0;
    localparam int PIN_CSN = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_FAULT = 3;
    localparam int PIN_WAKE = 5;
    localparam int PIN_STUCK = 7;
    localparam int PIN_RXD = 11;

    typedef struct packed {
        logic sclk;
        logic csn;
        logic sdi;
    } spi_in_s;

    typedef struct packed {
        logic [PIN_W-1:0] meta;
        logic [PIN_W-1:0] sync;
        logic sclk_prev;
        logic csn_prev;
        logic [4:0] bit_cnt;
        logic [15:0] shift_in;
        logic [15:0] out_word;
        logic sdo;
        logic sdo_oe;
        logic [DATA_W-1:0] cfg;
        logic [DATA_W-1:0] snap;
        logic [2:0] snap_addr;
        logic [1:0][BFT_CNT_W-1:0] bft_cnt;
        logic [1:0] fault;
        logic [1:0] quiet_req;
        logic [1:0] wake_evt;
        logic stuck_err;
        logic rxd;
        logic rxd_oe;
        logic spi_err;
        logic [DATA_W-1:0] gen_held;
        logic [1:0][DATA_W-1:0] br_held;
        logic [DATA_W-1:0] gen_shown;
        logic [1:0][DATA_W-1:0] br_shown;
    } cfg_state_s;

endpackage

/* File: rtl/star_cfg_reg.sv */
// configuration register of a two-branch active star coupler with its spi slave
// assumes spi pins and line conditions are asynchronous and pass two flip-flops first
`timescale 1ns/1ps
`default_nettype none

module star_cfg_reg #(
    parameter int BUS_FAIL_TIME_NS = star_cfg_pkg::BUS_FAIL_TIME_NS
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire star_cfg_pkg::spi_in_s spi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    input wire logic [1:0] branch_tx_fault_i,
    input wire logic [1:0] branch_wake_i,
    input wire logic [3:0] stuck_line_i,
    input wire logic rxd_data_i,
    input wire logic [11:0] gen_status_live_i,
    input wire logic [11:0] br1_status_live_i,
    input wire logic [11:0] br2_status_live_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic [1:0] branch_quiet_state_req_o,
    output logic [1:0] wake_event_o,
    output logic stuck_error_o,
    output logic spi_error_o,
    output logic auto_error_confine_en_o,
    output logic bus_fail_timer_en_o,
    output logic wake_detect_branch1_en_o,
    output logic wake_detect_branch2_en_o,
    output logic ctrl_port_en_o,
    output logic inner_star_port_en_o,
    output logic stuck_line_detect_en_o,
    output logic latching_en_o
);

    // =====================================================================
    // timing
    localparam int BFT_CYCLES_RAW = (BUS_FAIL_TIME_NS * star_cfg_pkg::CLK_MHZ + 999) / 1000;
    localparam int BFT_CYCLES = (BFT_CYCLES_RAW < 1) ? 1 : BFT_CYCLES_RAW;
    localparam logic [star_cfg_pkg::BFT_CNT_W-1:0] BFT_LIMIT =
        star_cfg_pkg::BFT_CNT_W'(BFT_CYCLES);

    star_cfg_pkg::cfg_state_s q, d;

    logic [star_cfg_pkg::PIN_W-1:0] pins;
    assign pins = {rxd_data_i, stuck_line_i, branch_wake_i, branch_tx_fault_i,
                   spi_i.sdi, spi_i.csn, spi_i.sclk};

    // parity bit makes the whole 12-bit word odd
    function automatic logic [11:0] with_parity(input logic [11:0] w);
        with_parity = {w[11:1], ~(^w[11:1])};
    endfunction

    // =====================================================================
    // next state
    always_comb
    begin
        logic sclk_rise;
        logic sclk_fall;
        logic csn_fall;
        logic csn_rise;
        logic [15:0] in_next;
        logic [2:0] addr;
        logic [11:0] resp;
        logic latch_en;
        logic [11:0] rel_gen;
        logic [1:0][11:0] rel_br;
        logic [1:0] wake_en;
        logic [1:0] fault_raw;
        logic [1:0][11:0] br_live;
        sclk_rise = 1'b0;
        sclk_fall = 1'b0;
        csn_fall = 1'b0;
        csn_rise = 1'b0;
        in_next = 16'h0000;
        addr = 3'h0;
        resp = 12'h000;
        latch_en = 1'b0;
        rel_gen = 12'h000;
        rel_br = '0;
        wake_en = 2'b00;
        fault_raw = 2'b00;
        br_live = '0;

        d = q;
        d.meta = pins;
        d.sync = q.meta;
        d.sclk_prev = q.sync[star_cfg_pkg::PIN_SCLK];
        d.csn_prev = q.sync[star_cfg_pkg::PIN_CSN];
        d.spi_err = 1'b0;

        sclk_rise = q.sync[star_cfg_pkg::PIN_SCLK] & ~q.sclk_prev;
        sclk_fall = ~q.sync[star_cfg_pkg::PIN_SCLK] & q.sclk_prev;
        csn_fall = ~q.sync[star_cfg_pkg::PIN_CSN] & q.csn_prev;
        csn_rise = q.sync[star_cfg_pkg::PIN_CSN] & ~q.csn_prev;
        in_next = {q.shift_in[14:0], q.sync[star_cfg_pkg::PIN_SDI]};
        latch_en = q.cfg[star_cfg_pkg::BIT_LATCHING];
        br_live[0] = br1_status_live_i;
        br_live[1] = br2_status_live_i;

        // ---- spi slave: sample on falling sclk, shift out on rising sclk
        if (csn_fall)
        begin
            d.bit_cnt = 5'h00;
            d.out_word = 16'h0000;
            d.sdo = 1'b0;
            d.sdo_oe = 1'b1;
        end
        else if (~q.sync[star_cfg_pkg::PIN_CSN])
        begin
            if (sclk_fall)
            begin
                d.shift_in = in_next;
                if (q.bit_cnt != 5'h1F)
                begin
                    d.bit_cnt = q.bit_cnt + 5'h01;
                end
                // response is chosen once the address bits are in
                if (q.bit_cnt + 5'h01 == star_cfg_pkg::ADDR_DONE)
                begin
                    addr = in_next[3:1];
                    case (addr)
                        star_cfg_pkg::ADDR_CONFIG: resp = with_parity(q.cfg);
                        star_cfg_pkg::ADDR_GEN_STATUS: resp = with_parity(q.gen_shown);
                        star_cfg_pkg::ADDR_BR1_STATUS: resp = with_parity(q.br_shown[0]);
                        star_cfg_pkg::ADDR_BR2_STATUS: resp = with_parity(q.br_shown[1]);
                        default: resp = 12'h000;
                    endcase
                    d.out_word = {4'h0, resp};
                    d.snap = resp;
                    d.snap_addr = addr;
                end
            end
            if (sclk_rise && q.bit_cnt != 5'h00 && q.bit_cnt < star_cfg_pkg::FRAME_LEN)
            begin
                d.sdo = q.out_word[4'(5'h0F - q.bit_cnt)];
            end
        end

        // ---- frame end: commit only complete 16-clock frames
        if (csn_rise)
        begin
            d.sdo_oe = 1'b0;
            d.sdo = 1'b0;
            if (q.bit_cnt == star_cfg_pkg::FRAME_LEN)
            begin
                addr = q.shift_in[star_cfg_pkg::ADDR_HI:star_cfg_pkg::ADDR_LO];
                if (addr == star_cfg_pkg::ADDR_CONFIG && !q.shift_in[star_cfg_pkg::RO_BIT])
                begin
                    // reserved bit 3 and parity bit 0 never store
                    d.cfg = q.shift_in[11:0] & star_cfg_pkg::CONFIG_WMASK;
                end
                // release follows the address that chose the returned word
                if (q.snap_addr == star_cfg_pkg::ADDR_GEN_STATUS)
                begin
                    rel_gen = q.snap;
                end
                if (q.snap_addr == star_cfg_pkg::ADDR_BR1_STATUS)
                begin
                    rel_br[0] = q.snap;
                end
                if (q.snap_addr == star_cfg_pkg::ADDR_BR2_STATUS)
                begin
                    rel_br[1] = q.snap;
                end
            end
            else
            begin
                d.spi_err = 1'b1;
            end
        end

        // ---- status latching: a read releases only what it returned;
        // a condition still live re-sets the bit, so set wins over release
        if (latch_en)
        begin
            d.gen_held = (q.gen_held & ~rel_gen) | gen_status_live_i;
            d.br_held[0] = (q.br_held[0] & ~rel_br[0]) | br_live[0];
            d.br_held[1] = (q.br_held[1] & ~rel_br[1]) | br_live[1];
            d.gen_shown = d.gen_held;
            d.br_shown = d.br_held;
        end
        else
        begin
            d.gen_held = 12'h000;
            d.br_held = '0;
            d.gen_shown = gen_status_live_i;
            d.br_shown = br_live;
        end

        // ---- branch fault filter and confinement
        fault_raw = q.sync[star_cfg_pkg::PIN_FAULT +: 2];
        for (int b = 0; b < 2; b++)
        begin
            if (!q.cfg[star_cfg_pkg::BIT_BUS_FAIL_TIMER])
            begin
                d.bft_cnt[b] = '0;
                d.fault[b] = fault_raw[b];
            end
            else if (!fault_raw[b])
            begin
                d.bft_cnt[b] = '0;
                d.fault[b] = 1'b0;
            end
            else if (q.bft_cnt[b] + 1'b1 >= BFT_LIMIT)
            begin
                d.fault[b] = 1'b1;
            end
            else
            begin
                d.bft_cnt[b] = q.bft_cnt[b] + 1'b1;
            end
            d.quiet_req[b] = q.cfg[star_cfg_pkg::BIT_AUTO_CONFINE] & q.fault[b];
        end

        // ---- wake, clamp and port gating
        wake_en = {q.cfg[star_cfg_pkg::BIT_WAKE_BR2], q.cfg[star_cfg_pkg::BIT_WAKE_BR1]};
        d.wake_evt = q.sync[star_cfg_pkg::PIN_WAKE +: 2] & wake_en;
        d.stuck_err = q.cfg[star_cfg_pkg::BIT_STUCK_DETECT]
                      & (|q.sync[star_cfg_pkg::PIN_STUCK +: 4]);
        d.rxd_oe = q.cfg[star_cfg_pkg::BIT_CTRL_PORT];
        d.rxd = q.cfg[star_cfg_pkg::BIT_CTRL_PORT] & q.sync[star_cfg_pkg::PIN_RXD];
    end

    // =====================================================================
    // state register
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            // presetting line inputs high would fake wake and clamp events after reset
            q.meta <= star_cfg_pkg::SYNC_RESET;
            q.sync <= star_cfg_pkg::SYNC_RESET;
            q.sclk_prev <= 1'b0;
            q.csn_prev <= 1'b1;
            q.cfg <= star_cfg_pkg::CONFIG_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // =====================================================================
    // outputs, all straight from the state register
    assign sdo_o = q.sdo;
    assign sdo_oe_o = q.sdo_oe;
    assign rxd_o = q.rxd;
    assign rxd_oe_o = q.rxd_oe;
    assign branch_quiet_state_req_o = q.quiet_req;
    assign wake_event_o = q.wake_evt;
    assign stuck_error_o = q.stuck_err;
    assign spi_error_o = q.spi_err;
    assign auto_error_confine_en_o = q.cfg[star_cfg_pkg::BIT_AUTO_CONFINE];
    assign bus_fail_timer_en_o = q.cfg[star_cfg_pkg::BIT_BUS_FAIL_TIMER];
    assign wake_detect_branch1_en_o = q.cfg[star_cfg_pkg::BIT_WAKE_BR1];
    assign wake_detect_branch2_en_o = q.cfg[star_cfg_pkg::BIT_WAKE_BR2];
    assign ctrl_port_en_o = q.cfg[star_cfg_pkg::BIT_CTRL_PORT];
    assign inner_star_port_en_o = q.cfg[star_cfg_pkg::BIT_INNER_STAR];
    assign stuck_line_detect_en_o = q.cfg[star_cfg_pkg::BIT_STUCK_DETECT];
    assign latching_en_o = q.cfg[star_cfg_pkg::BIT_LATCHING];

endmodule

`default_nettype wire

/* File: verification/star_cfg_reg_sva.sv */
// checker for the configuration block, bound at its ports
// assumes one core clock and an async active-high reset
`timescale 1ns/1ps
`default_nettype none
// =====
// port checks
module star_cfg_reg_sva #(
    parameter int BUS_FAIL_TIME_NS = star_cfg_pkg::BUS_FAIL_TIME_NS
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire star_cfg_pkg::spi_in_s spi_i,
    input wire logic sdo_oe_o,
    input wire logic [1:0] branch_tx_fault_i,
    input wire logic [3:0] stuck_line_i,
    input wire logic rxd_oe_o,
    input wire logic [1:0] branch_quiet_state_req_o,
    input wire logic [1:0] wake_event_o,
    input wire logic stuck_error_o,
    input wire logic spi_error_o,
    input wire logic auto_error_confine_en_o,
    input wire logic bus_fail_timer_en_o,
    input wire logic wake_detect_branch1_en_o,
    input wire logic wake_detect_branch2_en_o,
    input wire logic ctrl_port_en_o,
    input wire logic stuck_line_detect_en_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // only a short filter fits this window, so long filters are exempt
    sequence s_fault_held;
        (auto_error_confine_en_o && branch_tx_fault_i[0]
            && (BUS_FAIL_TIME_NS <= 24 || !bus_fail_timer_en_o)) [*8];
    endsequence
    sequence s_stuck_held;
        (stuck_line_detect_en_o && |stuck_line_i) [*6];
    endsequence
    a_quiet_gate: assert property (
        |branch_quiet_state_req_o |-> auto_error_confine_en_o || $past(auto_error_confine_en_o))
        else $error("quiet request without confinement");
    a_quiet_held: assert property (
        s_fault_held |-> branch_quiet_state_req_o[0])
        else $error("held fault gave no quiet request");
    a_wake_one: assert property (
        wake_event_o[0] |-> wake_detect_branch1_en_o || $past(wake_detect_branch1_en_o))
        else $error("wake on disabled branch 1");
    a_wake_two: assert property (
        wake_event_o[1] |-> wake_detect_branch2_en_o || $past(wake_detect_branch2_en_o))
        else $error("wake on disabled branch 2");
    a_rxd_off: assert property (
        !ctrl_port_en_o && !$past(ctrl_port_en_o) |-> !rxd_oe_o)
        else $error("receive driver on while port off");
    a_stuck_gate: assert property (
        stuck_error_o |-> stuck_line_detect_en_o || $past(stuck_line_detect_en_o))
        else $error("clamp error while detection off");
    a_stuck_raise: assert property (
        s_stuck_held |-> stuck_error_o)
        else $error("held clamp gave no error");
    a_oe_idle: assert property (
        spi_i.csn [*6] |=> !sdo_oe_o)
        else $error("data out driven while deselected");
    a_err_pulse: assert property (
        spi_error_o |=> !spi_error_o)
        else $error("frame error longer than a cycle");
    a_cfg_on_csn: assert property (
        $changed({auto_error_confine_en_o, bus_fail_timer_en_o, wake_detect_branch1_en_o,
            wake_detect_branch2_en_o, ctrl_port_en_o, stuck_line_detect_en_o})
        |-> $past(spi_i.csn, 3))
        else $error("configuration changed inside a frame");
endmodule

bind star_cfg_reg star_cfg_reg_sva #(.BUS_FAIL_TIME_NS(BUS_FAIL_TIME_NS)) i_sva (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_i(spi_i), .sdo_oe_o(sdo_oe_o),
    .branch_tx_fault_i(branch_tx_fault_i), .stuck_line_i(stuck_line_i), .rxd_oe_o(rxd_oe_o),
    .branch_quiet_state_req_o(branch_quiet_state_req_o), .wake_event_o(wake_event_o),
    .stuck_error_o(stuck_error_o), .spi_error_o(spi_error_o),
    .auto_error_confine_en_o(auto_error_confine_en_o),
    .bus_fail_timer_en_o(bus_fail_timer_en_o),
    .wake_detect_branch1_en_o(wake_detect_branch1_en_o),
    .wake_detect_branch2_en_o(wake_detect_branch2_en_o),
    .ctrl_port_en_o(ctrl_port_en_o), .stuck_line_detect_en_o(stuck_line_detect_en_o));
`default_nettype wire

/* File: verification/spi_host_model.sv */
// host side spi master clocking out the first n bits of a 16-bit frame
// assumes the core clock paces it; half sclk period is 8 core cycles
`timescale 1ns/1ps
`default_nettype none
// =====
// frame driver
module spi_host_model (
    input wire logic clk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output var star_cfg_pkg::spi_in_s spi_o
);
    initial spi_o = 3'h2;
    // sclk low at select, msb first, read back just before each falling edge
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        int i;
        r = '0;
        @(negedge clk_i);
        spi_o.csn = 1'b0;
        repeat (8) @(negedge clk_i);
        for (i = 0; i < n; i++)
        begin
            spi_o.sdi = w[15-i];
            spi_o.sclk = 1'b1;
            repeat (8) @(negedge clk_i);
            r[15-i] = sdo_oe_i ? sdo_i : 1'bx;
            spi_o.sclk = 1'b0;
            repeat (8) @(negedge clk_i);
        end
        spi_o.csn = 1'b1;
        // released line shows the inverse, not a stale bit
        spi_o.sdi = ~spi_o.sdi;
        repeat (8) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_star_cfg_reg.sv */
// self-checking bench for the configuration block over its spi link
// assumes the host model paces frames; filter time cut to two cycles
`timescale 1ns/1ps
`default_nettype none
// =====
// bench
module tb_star_cfg_reg;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    star_cfg_pkg::spi_in_s spi;
    logic sdo, sdo_oe, rxd_o, rxd_oe, stuck, spi_err, rxd_in = 1'b0;
    logic [1:0] fault = 2'h0, wake = 2'h0, quiet, wev, hit;
    logic [3:0] stuck_in = 4'h0;
    logic [11:0] gen_live = 12'h000;
    logic [11:0] br1_live = 12'h000;
    logic [11:0] br2_live = 12'h000;
    logic [7:0] en;
    logic [15:0] r;
    int err_count = 0, samples_checked = 0, spi_err_seen = 0;

    always #4 sys_clk_i = ~sys_clk_i;
    // looked at mid-cycle, where the one-cycle pulse has settled
    always @(negedge sys_clk_i) if (spi_err === 1'b1) spi_err_seen++;

    spi_host_model i_host (.clk_i(sys_clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .spi_o(spi));
    star_cfg_reg #(.BUS_FAIL_TIME_NS(16)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_i(spi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .branch_tx_fault_i(fault), .branch_wake_i(wake), .stuck_line_i(stuck_in),
        .rxd_data_i(rxd_in), .gen_status_live_i(gen_live), .br1_status_live_i(br1_live),
        .br2_status_live_i(br2_live), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe),
        .branch_quiet_state_req_o(quiet), .wake_event_o(wev), .stuck_error_o(stuck),
        .spi_error_o(spi_err), .auto_error_confine_en_o(en[7]), .bus_fail_timer_en_o(en[6]),
        .wake_detect_branch1_en_o(en[5]), .wake_detect_branch2_en_o(en[4]),
        .ctrl_port_en_o(en[3]), .inner_star_port_en_o(en[2]),
        .stuck_line_detect_en_o(en[1]), .latching_en_o(en[0]));

    function automatic logic [11:0] par(input logic [11:0] v);
        return {v[11:1], ~^v[11:1]};
    endfunction

    task close_out;
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [2:0] a, input logic [11:0] d);
        i_host.xfer({a, 1'b0, d}, 16, r);
    endtask

    task rd(input logic [2:0] a);
        i_host.xfer({a, 1'b1, 12'h000}, 16, r);
    endtask

    // enable outputs first, then the read-back word
    task cfg_is(input logic [11:0] v);
        chk({4'h0, en}, {4'h0, v[11:8], v[5:4], v[2:1]});
        rd(3'h7);
        chk(r[11:0], par(v & 12'hFF6));
    endtask

    task idle(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // one-cycle fault pulse on a settled low line, quiet requests collected in hit
    task glitch;
        fault = 2'h0;
        idle(6);
        fault = 2'h3;
        idle(1);
        fault = 2'h0;
        hit = 2'h0;
        repeat (10)
        begin
            @(negedge sys_clk_i);
            hit = hit | quiet;
        end
    endtask

    initial
    begin
        // the tests need about 5500 cycles; this allows roughly four and a half times that
        #200000;
        err_count++;
        close_out();
    end

    initial
    begin
        idle(8);
        rst_i = 1'b0;
        idle(4);
        cfg_is(12'h7D4);
        wr(3'h7, 12'hFFF);
        cfg_is(12'hFFF);
        fault = 2'h3;
        wake = 2'h3;
        stuck_in = 4'hF;
        rxd_in = 1'b1;
        idle(12);
        chk({5'h0, quiet, wev, stuck, rxd_oe, rxd_o}, 12'h07F);
        i_host.xfer({3'h7, 1'b0, 12'h000}, 15, r);
        chk(12'(spi_err_seen), 12'h001);
        wr(3'h2, 12'h000);
        i_host.xfer({3'h7, 1'b1, 12'h000}, 16, r);
        cfg_is(12'hFFF);
        // a one-cycle glitch must not reach the quiet request
        glitch();
        chk({10'h0, hit}, 12'h000);
        wr(3'h7, 12'hA24);
        cfg_is(12'hA24);
        fault = 2'h3;
        idle(12);
        chk({5'h0, quiet, wev, stuck, rxd_oe, rxd_o}, 12'h06F);
        // with the filter off the same glitch passes straight through
        glitch();
        chk({10'h0, hit}, 12'h003);
        wr(3'h7, 12'h000);
        fault = 2'h3;
        idle(12);
        chk({5'h0, quiet, wev, stuck, rxd_oe, rxd_o}, 12'h000);
        cfg_is(12'h000);
        gen_live = 12'hA50;
        br1_live = 12'h30C;
        br2_live = 12'h0F0;
        rd(3'h2);
        chk(r[11:0], par(12'hA50));
        rd(3'h3);
        chk(r[11:0], par(12'h30C));
        rd(3'h4);
        chk(r[11:0], par(12'h0F0));
        gen_live = 12'h000;
        br1_live = 12'h000;
        br2_live = 12'h000;
        wr(3'h7, 12'h002);
        rd(3'h2);
        gen_live = 12'h800;
        br2_live = 12'h010;
        idle(4);
        gen_live = 12'h000;
        br2_live = 12'h000;
        rd(3'h2);
        chk(r[11:0], par(12'h800));
        // reading the general register must leave the branch latch alone
        rd(3'h4);
        chk(r[11:0], par(12'h010));
        rd(3'h2);
        chk(r[11:0], par(12'h000));
        rd(3'h4);
        chk(r[11:0], par(12'h000));
        close_out();
    end
endmodule
`default_nettype wire
